// ==== src/rsc_reset_source_controller.sv ====
/*
 * Reset source controller: merges pin, missing clock, comparator,
 * watchdog, flash error, software and supply monitor causes into one
 * registered system reset, and keeps the cause and enable register.
 * Assumes all inputs synchronous to clk_i; rst_n_i is the power-on
 * reset of this block alone and survives no other reset.
 */
// The plain strobed port was decided locally.
`include "rsc_defs.svh"

module rsc_reset_source_controller (
    input wire logic clk_i, // 250 MHz system clock
    input wire logic rst_n_i, // Power-on reset, sync, active low
    input wire logic rst_pin_n_i, // External reset pin level
    input wire logic system_clock_i, // Sampled clock watched by detector
    input wire logic cmp_noninv_below_i, // Comparator 0 output, low sense
    input wire logic vdd_mon_enable_i, // Supply monitor switched on
    input wire logic vdd_high_level_i, // Supply monitor at high threshold
    input wire logic vdd_low_i, // Supply at or below threshold
    input wire logic wdt_kick_i, // Watchdog update pulse
    input wire logic wdt_disable_i, // Watchdog disable pulse
    input wire logic program_store_write_enable_i, // Store write enable
    input wire rsc_pkg::rsc_flash_req_t flash_req_i, // Flash events
    input wire logic [`RSC_ADDR_W-1:0] addr_i, // Register address
    input wire logic [`RSC_DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [`RSC_DATA_W-1:0] rdata_o, // Read data, next cycle
    output logic sys_rst_n_o, // System reset, active low
    output logic wdt_enabled_o // Watchdog enable state
);

    rsc_pkg::rsc_state_t state;
    rsc_pkg::rsc_state_t next_state;
    rsc_pkg::rsc_cause_t cause;
    rsc_pkg::rsc_cause_t next_cause;
    logic [`RSC_NUM_FLAGS-1:0] flags;
    logic [`RSC_HOLD_CNT_W-1:0] hold_cnt;
    logic mcd_en;
    logic cmp_en;
    logic vdm_en;
    logic clk_seen;
    logic [`RSC_MCD_CNT_W-1:0] mcd_cnt;
    logic [`RSC_WDT_DIV_W-1:0] wdt_div;
    logic [`RSC_WDT_CNT_W-1:0] wdt_cnt;
    logic wdt_tick;
    logic in_run;
    logic reg_wr;
    logic pin_cause;
    logic por_cause;
    logic mcd_cause;
    logic cmp_cause;
    logic wdt_cause;
    logic sw_cause;
    logic ferr_cause;
    logic any_cause;

    localparam logic [`RSC_MCD_CNT_W-1:0] MCD_LIMIT =
        `RSC_MCD_CNT_W'(`RSC_MCD_TIMEOUT_CYC);
    localparam logic [`RSC_WDT_DIV_W-1:0] WDT_DIV_LAST =
        `RSC_WDT_DIV_W'(`RSC_WDT_DIV - 1);
    localparam logic [`RSC_HOLD_CNT_W-1:0] HOLD_LAST =
        `RSC_HOLD_CNT_W'(`RSC_HOLD_CYC - 1);

    assign in_run = (state == rsc_pkg::RSC_ST_RUN);
    assign reg_wr = wr_i && (addr_i == `RSC_REG_OFS);

    // Cause detection
    assign pin_cause = !rst_pin_n_i;
    assign por_cause = vdm_en && vdd_low_i;
    assign mcd_cause = mcd_en && (mcd_cnt >= MCD_LIMIT);
    assign cmp_cause = cmp_en && cmp_noninv_below_i;
    assign wdt_cause = wdt_enabled_o && wdt_tick && (&wdt_cnt);
    assign sw_cause = reg_wr && wdata_i[`RSC_BIT_SW];
    assign ferr_cause =
        (program_store_write_enable_i && flash_req_i.xdata_write &&
         flash_req_i.xdata_addr >= `RSC_FLASH_RESERVED_BASE) ||
        (flash_req_i.code_read &&
         flash_req_i.code_addr >= `RSC_FLASH_RESERVED_BASE) ||
        (flash_req_i.branch_fetch &&
         flash_req_i.fetch_addr >= `RSC_FLASH_RESERVED_BASE) ||
        flash_req_i.security_block ||
        (flash_req_i.flash_access &&
         !(vdd_mon_enable_i && vdd_high_level_i && vdm_en));
    assign any_cause = pin_cause || por_cause || mcd_cause || cmp_cause ||
        wdt_cause || sw_cause || ferr_cause;

    // Priority of causes that coincide
    always_comb begin
        if (por_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_POR;
        end else if (pin_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_PIN;
        end else if (mcd_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_MCD;
        end else if (cmp_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_CMP;
        end else if (wdt_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_WDT;
        end else if (ferr_cause) begin
            next_cause = rsc_pkg::RSC_CAUSE_FERR;
        end else begin
            next_cause = rsc_pkg::RSC_CAUSE_SW;
        end
    end

    // Sequencer: hold reset for a minimum time and while a level persists
    always_comb begin
        case (state)
            rsc_pkg::RSC_ST_RUN: begin
                next_state = any_cause ? rsc_pkg::RSC_ST_HOLD
                                       : rsc_pkg::RSC_ST_RUN;
            end
            rsc_pkg::RSC_ST_HOLD: begin
                if (pin_cause || por_cause || hold_cnt != HOLD_LAST) begin
                    next_state = rsc_pkg::RSC_ST_HOLD;
                end else begin
                    next_state = rsc_pkg::RSC_ST_RUN;
                end
            end
            default: begin
                next_state = rsc_pkg::RSC_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= rsc_pkg::RSC_ST_HOLD;
            sys_rst_n_o <= 1'b0;
        end else begin
            state <= next_state;
            sys_rst_n_o <= (next_state == rsc_pkg::RSC_ST_RUN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hold_cnt <= '0;
        end else if (in_run || hold_cnt == HOLD_LAST) begin
            hold_cnt <= in_run ? '0 : hold_cnt;
        end else begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end

    // Cause capture; a supply drop during the hold takes over
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cause <= rsc_pkg::RSC_CAUSE_POR;
        end else if ((in_run && any_cause) || (!in_run && por_cause)) begin
            cause <= next_cause;
        end
    end

    // Flags written once, on leaving reset; only the cause bit is set
    generate
        for (genvar i = 0; i < `RSC_NUM_FLAGS; i++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    flags[i] <= 1'b0;
                end else if (!in_run && next_state == rsc_pkg::RSC_ST_RUN)
                begin
                    flags[i] <= (cause == 3'(i));
                end
            end
        end
    endgenerate

    // Source enables, written whole from the byte
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mcd_en <= 1'b0;
            cmp_en <= 1'b0;
            vdm_en <= 1'b1;
        end else if (!in_run) begin
            mcd_en <= 1'b0;
            cmp_en <= 1'b0;
        end else if (reg_wr) begin
            mcd_en <= wdata_i[`RSC_BIT_MCD];
            cmp_en <= wdata_i[`RSC_BIT_CMP];
            vdm_en <= wdata_i[`RSC_BIT_POR];
        end
    end

    // Missing clock one-shot, retriggered by every level change
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clk_seen <= 1'b0;
            mcd_cnt <= '0;
        end else begin
            clk_seen <= system_clock_i;
            if (!in_run || !mcd_en || system_clock_i != clk_seen) begin
                mcd_cnt <= '0;
            end else if (mcd_cnt != MCD_LIMIT) begin
                mcd_cnt <= mcd_cnt + 1'b1;
            end
        end
    end

    // Watchdog prescaler: one tick every twelve clocks
    assign wdt_tick = (wdt_div == WDT_DIV_LAST);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !in_run || wdt_tick) begin
            wdt_div <= '0;
        end else begin
            wdt_div <= wdt_div + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !in_run) begin
            wdt_enabled_o <= 1'b1;
            wdt_cnt <= '0;
        end else begin
            if (wdt_disable_i) begin
                wdt_enabled_o <= 1'b0;
            end
            if (wdt_kick_i) begin
                wdt_cnt <= '0;
            end else if (wdt_enabled_o && wdt_tick) begin
                wdt_cnt <= wdt_cnt + 1'b1;
            end
        end
    end

    // Read port; data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i && addr_i == `RSC_REG_OFS) begin
            rdata_o <= {1'b0, flags};
        end else begin
            rdata_o <= '0;
        end
    end

    // Checks
    // Eleven running cycles, split to keep each repetition short
    sequence s_run_cycles;
        in_run [*8] ##1 in_run [*3];
    endsequence

    sequence s_leave_reset;
        $rose(sys_rst_n_o);
    endsequence

    a_pin_forces_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && !rst_pin_n_i) |=> !sys_rst_n_o [*2])
        else $error("pin low did not hold reset");

    a_pin_holds_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !rst_pin_n_i |=> !sys_rst_n_o)
        else $error("reset released while pin low");

    a_mcd_timeout: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && mcd_en && mcd_cnt == MCD_LIMIT) |=> !sys_rst_n_o)
        else $error("missing clock did not reset");

    a_mcd_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_MCD] == (cause == rsc_pkg::RSC_CAUSE_MCD))
        else $error("missing clock flag wrong");

    a_mcd_disabled: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && reg_wr && !wdata_i[`RSC_BIT_MCD]) |=> !mcd_cause)
        else $error("detector still armed after clear");

    a_cmp_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && cmp_en && cmp_noninv_below_i) |=>
            (!sys_rst_n_o && cause != rsc_pkg::RSC_CAUSE_SW))
        else $error("comparator did not reset");

    a_wdt_prescale: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (wdt_tick && in_run) ##1 s_run_cycles |=> wdt_tick)
        else $error("watchdog tick not every twelve clocks");

    a_wdt_up_enabled: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |-> (wdt_enabled_o && wdt_cnt == '0))
        else $error("watchdog not enabled after reset");

    a_wdt_overflow: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && wdt_cause && !por_cause && !pin_cause && !mcd_cause &&
         !cmp_cause) |=> (!sys_rst_n_o && cause == rsc_pkg::RSC_CAUSE_WDT))
        else $error("watchdog overflow not taken");

    a_ferr_flag: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_FERR] == (cause == rsc_pkg::RSC_CAUSE_FERR))
        else $error("flash error flag wrong");

    a_sw_force: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && sw_cause) |=> !sys_rst_n_o ##1 !sys_rst_n_o)
        else $error("software write did not reset");

    a_monitor_gated: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && !any_cause) |=> sys_rst_n_o)
        else $error("reset without a cause");

    a_hold_length: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run && any_cause) |=> !sys_rst_n_o [*8])
        else $error("reset shorter than hold time");

    a_bit7_zero: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(rd_i) |-> rdata_o[7] == 1'b0)
        else $error("bit 7 not zero");

    a_pin_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_PIN] == (cause == rsc_pkg::RSC_CAUSE_PIN))
        else $error("pin flag wrong");

    a_por_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_POR] == (cause == rsc_pkg::RSC_CAUSE_POR))
        else $error("power-on flag wrong");

    a_cmp_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_CMP] == (cause == rsc_pkg::RSC_CAUSE_CMP))
        else $error("comparator flag wrong");

    a_sw_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_SW] == (cause == rsc_pkg::RSC_CAUSE_SW))
        else $error("software flag wrong");

    a_wdt_flag_cause: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_leave_reset |->
            flags[`RSC_BIT_WDT] == (cause == rsc_pkg::RSC_CAUSE_WDT))
        else $error("watchdog flag wrong");

    a_flags_steady: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_run ##1 in_run) |-> $stable(flags))
        else $error("flags changed while running");

    a_enables_cleared: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !in_run |=> (!mcd_en && !cmp_en))
        else $error("source enables survived reset");

endmodule // rsc_reset_source_controller

// ==== src/rsc_defs.svh ====
/*
 * Constants of the reset source controller: register offset, field
 * positions, timing figures and derived cycle counts.
 * Assumes a 250 MHz system clock and an 8-bit register port.
 */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// Register map
`define RSC_REG_OFS 8'hEF
`define RSC_ADDR_W 8
`define RSC_DATA_W 8

// Field positions of reset_cause_and_enable
`define RSC_BIT_PIN 3'h0
`define RSC_BIT_POR 3'h1
`define RSC_BIT_MCD 3'h2
`define RSC_BIT_WDT 3'h3
`define RSC_BIT_SW 3'h4
`define RSC_BIT_CMP 3'h5
`define RSC_BIT_FERR 3'h6
`define RSC_NUM_FLAGS 7

// Timing
`define RSC_CLK_PERIOD_NS 4
`define RSC_MCD_TIMEOUT_NS 500
`define RSC_MCD_TIMEOUT_CYC ((`RSC_MCD_TIMEOUT_NS) / (`RSC_CLK_PERIOD_NS))
`define RSC_MCD_CNT_W 8
`define RSC_WDT_DIV 12
`define RSC_WDT_DIV_W 4
`define RSC_WDT_CNT_W 16
`define RSC_HOLD_CYC 8
`define RSC_HOLD_CNT_W 4

// Flash layout
`define RSC_FLASH_ADDR_W 16
`define RSC_FLASH_RESERVED_BASE 16'hFC00

`endif

// ==== src/rsc_pkg.sv ====
/*
 * Types of the reset source controller: sequencer states, reset causes
 * and the bundle of flash access events.
 * Assumes rsc_defs.svh is on the include path.
 */
`include "rsc_defs.svh"

package rsc_pkg;

    typedef enum logic [1:0] {
        RSC_ST_RUN = 2'b01,
        RSC_ST_HOLD = 2'b10
    } rsc_state_t;

    // Code of each cause equals its flag position in the register
    typedef enum logic [2:0] {
        RSC_CAUSE_PIN = 3'h0,
        RSC_CAUSE_POR = 3'h1,
        RSC_CAUSE_MCD = 3'h2,
        RSC_CAUSE_WDT = 3'h3,
        RSC_CAUSE_SW = 3'h4,
        RSC_CAUSE_CMP = 3'h5,
        RSC_CAUSE_FERR = 3'h6
    } rsc_cause_t;

    typedef struct packed {
        logic xdata_write;
        logic [`RSC_FLASH_ADDR_W-1:0] xdata_addr;
        logic code_read;
        logic [`RSC_FLASH_ADDR_W-1:0] code_addr;
        logic branch_fetch;
        logic [`RSC_FLASH_ADDR_W-1:0] fetch_addr;
        logic security_block;
        logic flash_access;
    } rsc_flash_req_t;

endpackage

// ==== sim/rsc_ext_rst_model.sv ====
/*
 * External reset circuitry: pulls the reset pin low for a set time.
 * Assumes a one-cycle go_i pulse from the bench; idle pin is pulled up.
 */
module rsc_ext_rst_model (
    input wire logic clk_i, // System clock
    input wire logic go_i, // Start one low pulse
    input wire logic [7:0] len_i, // Cycles to hold the pin low
    output logic rst_pin_n_o // Pin level seen by the device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left = 8'h00;
    always @(posedge clk_i) begin
        if (go_i) begin
            left <= len_i;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // Only this model drives the pin; released pin sits at pull-up
    assign rst_pin_n_o = (left == 8'h00);
endmodule // rsc_ext_rst_model

// ==== sim/rsc_reset_source_controller_tb_top.sv ====
/*
 * Bench of the reset source controller: register master, pin model,
 * flash events, comparator and supply inputs, one task per case.
 * Assumes the package and rsc_defs.svh are compiled first.
 */
`include "rsc_defs.svh"
module rsc_reset_source_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sck = 1'b0;
    logic sck_run = 1'b1;
    logic cmp = 1'b0;
    logic mon_en = 1'b1;
    logic vhigh = 1'b1;
    logic vlow = 1'b0;
    logic kick = 1'b0;
    logic wdis = 1'b0;
    logic program_store_write_enable = 1'b0;
    rsc_pkg::rsc_flash_req_t freq = '0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [7:0] len = 8'h00;
    logic pin_n;
    logic [7:0] rdata;
    logic srst_n;
    logic wdt_en;
    int err_count = 0;
    int num_checks = 0;
    int n;

    rsc_reset_source_controller rsc_reset_source_controller_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .rst_pin_n_i(pin_n),
        .system_clock_i(sck), .cmp_noninv_below_i(cmp),
        .vdd_mon_enable_i(mon_en), .vdd_high_level_i(vhigh),
        .vdd_low_i(vlow), .wdt_kick_i(kick), .wdt_disable_i(wdis),
        .program_store_write_enable_i(program_store_write_enable), .flash_req_i(freq),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .sys_rst_n_o(srst_n), .wdt_enabled_o(wdt_en)
    );
    rsc_ext_rst_model rsc_ext_rst_model_inst (
        .clk_i(clk_i), .go_i(go), .len_i(len), .rst_pin_n_o(pin_n)
    );

    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Watched clock toggles every cycle unless stopped
    always @(posedge clk_i) begin
        if (sck_run) sck <= ~sck;
    end

    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        chk("rdata", e, rdata);
    endtask
    // Counts low cycles until the system leaves reset
    task automatic wait_run(output int cnt);
        cnt = 0;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_i);
            if (srst_n === 1'b1) return;
            cnt++;
        end
        err_count++;
        conclude();
    endtask
    task automatic rst_in(input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_i);
            if (srst_n === 1'b0) return;
        end
        err_count++;
        conclude();
    endtask
    task automatic no_rst(input int cyc);
        logic seen;
        seen = 1'b0;
        repeat (cyc) begin
            @(negedge clk_i);
            if (srst_n !== 1'b1) seen = 1'b1;
        end
        chk("no reset", 8'h00, {7'h00, seen});
    endtask
    task automatic fev(input int k);
        rsc_pkg::rsc_flash_req_t f;
        f = '0;
        f.xdata_write = (k < 2) || (k == 6);
        f.xdata_addr = 16'(`RSC_FLASH_RESERVED_BASE - ((k == 1) ? 1 : 0));
        f.code_read = (k == 2);
        f.code_addr = `RSC_FLASH_RESERVED_BASE;
        f.branch_fetch = (k == 3);
        f.fetch_addr = 16'hFFFF;
        f.security_block = (k == 4);
        f.flash_access = (k == 5) || (k >= 7);
        @(posedge clk_i);
        freq <= f;
        program_store_write_enable <= (k != 6);
        vhigh <= (k != 7);
        mon_en <= (k != 8);
        @(posedge clk_i);
        freq <= '0;
        vhigh <= 1'b1;
        mon_en <= 1'b1;
    endtask

    task automatic t_por();
        wait_run(n);
        rd_reg(`RSC_REG_OFS, 8'h02);
        chk("wdt_enabled", 8'h01, {7'h00, wdt_en});
        rd_reg(8'h00, 8'h00);
        wr_reg(8'h00, 8'h10);
        no_rst(20);
    endtask
    task automatic t_sw();
        wr_reg(`RSC_REG_OFS, 8'hDB);
        @(negedge clk_i);
        chk("sys_rst_n", 8'h00, {7'h00, srst_n});
        wait_run(n);
        chk("hold", `RSC_HOLD_CYC, 8'(n + 1));
        rd_reg(`RSC_REG_OFS, 8'h10);
    endtask
    task automatic t_wdt();
        @(posedge clk_i);
        kick <= 1'b1;
        wdis <= 1'b1;
        @(posedge clk_i);
        kick <= 1'b0;
        wdis <= 1'b0;
        @(negedge clk_i);
        chk("wdt_enabled", 8'h00, {7'h00, wdt_en});
        wr_reg(`RSC_REG_OFS, 8'h12);
        rst_in(2);
        wait_run(n);
        chk("wdt_enabled", 8'h01, {7'h00, wdt_en});
    endtask
    task automatic t_pin();
        @(posedge clk_i);
        go <= 1'b1;
        len <= 8'd20;
        @(posedge clk_i);
        go <= 1'b0;
        rst_in(3);
        wait_run(n);
        chk("pin hold", 8'h01, {7'h00, n >= 18});
        rd_reg(`RSC_REG_OFS, 8'h01);
    endtask
    task automatic t_mcd();
        wr_reg(`RSC_REG_OFS, 8'h06);
        sck_run <= 1'b0;
        no_rst(`RSC_MCD_TIMEOUT_CYC - 5);
        rst_in(15);
        sck_run <= 1'b1;
        wait_run(n);
        rd_reg(`RSC_REG_OFS, 8'h04);
        wr_reg(`RSC_REG_OFS, 8'h06);
        wr_reg(`RSC_REG_OFS, 8'h02);
        sck_run <= 1'b0;
        no_rst(200);
        sck_run <= 1'b1;
    endtask
    task automatic t_cmp();
        @(posedge clk_i);
        cmp <= 1'b1;
        no_rst(10);
        @(posedge clk_i);
        cmp <= 1'b0;
        wr_reg(`RSC_REG_OFS, 8'h22);
        no_rst(10);
        @(posedge clk_i);
        cmp <= 1'b1;
        rst_in(3);
        @(posedge clk_i);
        cmp <= 1'b0;
        wait_run(n);
        rd_reg(`RSC_REG_OFS, 8'h20);
    endtask
    task automatic t_flash();
        logic [8:0] hit;
        hit = 9'b1_1001_1101;
        for (int k = 0; k < 9; k++) begin
            fev(k);
            if (hit[k]) begin
                rst_in(3);
                wait_run(n);
                rd_reg(`RSC_REG_OFS, 8'h40);
            end else begin
                no_rst(10);
            end
        end
    endtask
    task automatic t_vdd();
        wr_reg(`RSC_REG_OFS, 8'h00);
        vlow <= 1'b1;
        no_rst(10);
        @(posedge clk_i);
        vlow <= 1'b0;
        wr_reg(`RSC_REG_OFS, 8'h02);
        vlow <= 1'b1;
        rst_in(3);
        repeat (4) @(posedge clk_i);
        vlow <= 1'b0;
        wait_run(n);
        rd_reg(`RSC_REG_OFS, 8'h02);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_por();
        t_sw();
        t_wdt();
        t_pin();
        t_mcd();
        t_cmp();
        t_flash();
        t_vdd();
        conclude();
    end
endmodule // rsc_reset_source_controller_tb_top
